// ==== common/awdc_pkg.sv ====
// package: register map, field positions, timing and carrier types of the watchdog control
package awdc_pkg;
  // ****************************************************************
  // register map
  // ****************************************************************
  localparam int unsigned CTRL_INDEX     = 32'h0000000a;
  localparam int unsigned STATUS_INDEX   = 32'h0000000b;
  localparam int unsigned MASK_INDEX     = 32'h0000000c;
  localparam logic [7:0]  CTRL_RESET     = 8'h00;
  localparam logic [7:0]  STATUS_RESET   = 8'h00;
  localparam logic [7:0]  MASK_RESET     = 8'h00;
  // control bit positions
  localparam int unsigned BIT_RATE       = 0;
  localparam int unsigned BIT_FLAG       = 1;
  localparam int unsigned BIT_CYCLIC     = 2;
  localparam int unsigned BIT_IRQ_EN     = 3;
  localparam int unsigned BIT_RST_EN     = 4;
  localparam int unsigned BIT_RESTART    = 5;
  // status bit positions (sticky events)
  localparam int unsigned EV_TIMEOUT     = 0;
  localparam int unsigned EV_WAKE        = 1;
  localparam int unsigned EV_HALL        = 2;
  localparam logic [7:0]  EV_USED        = 8'h07;
  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned CLK_HZ         = 10_000_000;
  localparam int unsigned FAST_MS        = 10;
  localparam int unsigned SLOW_MS        = 20;
  localparam int unsigned TICK_US        = 1000;
  localparam int unsigned TICK_CYCLES    = CLK_HZ / 1_000_000 * TICK_US;
  localparam int unsigned FAST_TICKS     = FAST_MS * 1000 / TICK_US;
  localparam int unsigned SLOW_TICKS     = SLOW_MS * 1000 / TICK_US;
  // ****************************************************************
  // carrier types
  // ****************************************************************
  typedef struct packed {
    logic       cyc;
    logic       stb;
    logic       we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } awdc_wb_req_type;
  typedef struct packed {
    logic        rst_en;
    logic        irq_en;
    logic        cyclic;
    logic        flag;
    logic        rate;
  } awdc_ctrl_type;
endpackage : awdc_pkg

// ==== logic/awdc_osc.sv ====
// file: internal watchdog oscillator tick generator, gated by run enable
`timescale 1ns/1ps
`default_nettype none
module awdc_osc #(
  parameter int unsigned DIV = awdc_pkg::TICK_CYCLES
) (
  input  wire logic sys_clk,
  input  wire logic reset,
  input  wire logic run,
  output var  logic tick
);
  localparam int unsigned W = $clog2(DIV + 1);
  logic [W-1:0] div_reg;
  initial begin
    if (DIV < 2) $error("awdc_osc: divider too small");
  end
  // ****************************************************************
  // divider: stops and clears when disabled
  // ****************************************************************
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      div_reg <= '0;
      tick    <= 1'b0;
    end else if (!run) begin
      div_reg <= '0;
      tick    <= 1'b0;
    end else if (div_reg == W'(DIV - 1)) begin
      div_reg <= '0;
      tick    <= 1'b1;
    end else begin
      div_reg <= div_reg + W'(1);
      tick    <= 1'b0;
    end
  end
endmodule // awdc_osc
`default_nettype wire

// ==== logic/awdc_top.sv ====
// file: watchdog control block with classic wishbone slave and interrupt logic
`timescale 1ns/1ps
`default_nettype none
// Function
// - the restart bit is write only and always reads back zero.
// - writing one to restart clears the counter and starts a new period, zero does nothing.
// - with reset enable set a timeout pulls the active low system reset, only in run mode.
// - reset enable can be set once after each reset and cannot be cleared by software.
// - with interrupt enable set a set timeout flag pulls the active low interrupt in stop mode.
// - cyclic check enable turns periodic sampling of hall and analog inputs on or off.
// - the timeout flag sets on timeout, writing one clears it, writing zero does nothing.
// - clearing the timeout flag also restarts the counter.
// - rate select one gives a 10 ms period and zero gives 20 ms.
// - system reset clears the whole control register to zero.
// - the oscillator runs only while reset, interrupt or cyclic enable is set.
// - the reset watchdog stops counting in stop mode unless interrupt or cyclic enable is set, and resumes in run mode.
// - in stop mode with interrupt enable set the block wakes the system each period.
// - during cyclic wake the hall inputs are powered and sampled, waking on a high input.
module awdc_top #(
  parameter int unsigned TICK_DIV  = awdc_pkg::TICK_CYCLES,
  parameter int unsigned HALL_W    = 3
) (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output var  logic [31:0] wb_dat_o,
  output var  logic        wb_ack_o,
  input  wire logic        stop_mode,
  input  wire logic [HALL_W-1:0] hall_in,
  input  wire logic        hall_irq_en,
  output var  logic        sys_reset_n,
  output var  logic        cpu_irq_n,
  output var  logic        wake_req,
  output var  logic        hall_power,
  output var  logic        analog_check,
  output var  logic        irq
);
  initial begin
    if (HALL_W < 1 || HALL_W > 8) $error("awdc_top: hall width out of range");
  end
  // ****************************************************************
  // declarations
  // ****************************************************************
  localparam int unsigned CW = $clog2(awdc_pkg::SLOW_TICKS + 1);
  typedef enum logic [2:0] {
    CYC_IDLE   = 3'b001,
    CYC_POWER  = 3'b010,
    CYC_SAMPLE = 3'b100
  } awdc_cyc_type;
  awdc_pkg::awdc_wb_req_type req;
  awdc_pkg::awdc_ctrl_type   ctrl_reg;
  logic [CW-1:0] cnt_reg;
  logic [7:0]    status_reg;
  logic [7:0]    mask_reg;
  logic [7:0]    ev_next;
  awdc_cyc_type  cyc_reg;
  logic          tick;
  logic          run_osc;
  logic          wr_ctrl;
  logic          restart;
  logic          flag_clear;
  logic          timeout;
  logic          counting;
  logic          hall_hit;
  logic [CW-1:0] end_value;

  // decode a register index, word aligned
  function automatic logic hit(input logic [7:0] adr, input int unsigned idx);
    return adr == 8'(idx * 4);
  endfunction

  assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, adr: wb_adr_i,
                 sel: wb_sel_i, dat: wb_dat_i};
  // write strobe into control, lane 0 only
  assign wr_ctrl    = req.cyc && req.stb && req.we && !wb_ack_o && req.sel[0]
                      && hit(req.adr, awdc_pkg::CTRL_INDEX);
  assign restart    = wr_ctrl && req.dat[awdc_pkg::BIT_RESTART];
  assign flag_clear = wr_ctrl && req.dat[awdc_pkg::BIT_FLAG] && ctrl_reg.flag;
  // ****************************************************************
  // oscillator and timeout counter
  // ****************************************************************
  assign run_osc   = ctrl_reg.rst_en || ctrl_reg.irq_en || ctrl_reg.cyclic;
  // reset function alone pauses in stop mode
  assign counting  = run_osc && !(stop_mode && !ctrl_reg.irq_en && !ctrl_reg.cyclic);
  assign end_value = ctrl_reg.rate ? CW'(awdc_pkg::FAST_TICKS)
                                   : CW'(awdc_pkg::SLOW_TICKS);
  assign timeout   = tick && counting && (cnt_reg >= end_value - CW'(1));

  awdc_osc #(
    .DIV (TICK_DIV)
  ) u_osc (
    .sys_clk (sys_clk),
    .reset   (reset),
    .run     (run_osc),
    .tick    (tick)
  );

  // counter of oscillator ticks
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cnt_reg <= '0;
    end else if (!run_osc || restart || flag_clear || timeout) begin
      cnt_reg <= '0;
    end else if (tick && counting) begin
      cnt_reg <= cnt_reg + CW'(1);
    end
  end
  // ****************************************************************
  // control register
  // ****************************************************************
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ctrl_reg <= awdc_pkg::awdc_ctrl_type'(5'h00);
    end else begin
      if (wr_ctrl) begin
        ctrl_reg.irq_en <= req.dat[awdc_pkg::BIT_IRQ_EN];
        ctrl_reg.cyclic <= req.dat[awdc_pkg::BIT_CYCLIC];
        ctrl_reg.rate   <= req.dat[awdc_pkg::BIT_RATE];
        if (req.dat[awdc_pkg::BIT_RST_EN]) begin
          ctrl_reg.rst_en <= 1'b1;
        end
      end
      // set wins over a simultaneous clear
      if (timeout) begin
        ctrl_reg.flag <= 1'b1;
      end else if (flag_clear) begin
        ctrl_reg.flag <= 1'b0;
      end
    end
  end
  // ****************************************************************
  // system outputs
  // ****************************************************************
  // reset in run mode, interrupt in stop mode
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sys_reset_n <= 1'b1;
      cpu_irq_n   <= 1'b1;
      wake_req    <= 1'b0;
    end else begin
      sys_reset_n <= !(timeout && ctrl_reg.rst_en && !stop_mode);
      cpu_irq_n   <= !((ctrl_reg.flag || hall_hit) && ctrl_reg.irq_en
                       && stop_mode);
      wake_req    <= stop_mode && ((timeout && ctrl_reg.irq_en) || hall_hit);
    end
  end
  // ****************************************************************
  // cyclic sensor check
  // ****************************************************************
  assign hall_hit = (cyc_reg == CYC_SAMPLE) && (|hall_in) && hall_irq_en;
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cyc_reg      <= CYC_IDLE;
      hall_power   <= 1'b0;
      analog_check <= 1'b0;
    end else begin
      case (cyc_reg)
        CYC_IDLE: begin
          if (ctrl_reg.cyclic && stop_mode && timeout) begin
            cyc_reg      <= CYC_POWER;
            hall_power   <= 1'b1;
            analog_check <= 1'b1;
          end
        end
        CYC_POWER: begin
          cyc_reg <= CYC_SAMPLE;
        end
        CYC_SAMPLE: begin
          cyc_reg      <= CYC_IDLE;
          hall_power   <= 1'b0;
          analog_check <= 1'b0;
        end
        default: begin
          cyc_reg <= CYC_IDLE;
        end
      endcase
      if (!ctrl_reg.cyclic) begin
        cyc_reg      <= CYC_IDLE;
        hall_power   <= 1'b0;
        analog_check <= 1'b0;
      end
    end
  end
  // ****************************************************************
  // interrupt status and mask
  // ****************************************************************
  always_comb begin
    ev_next = 8'h00;
    ev_next[awdc_pkg::EV_TIMEOUT] = timeout;
    ev_next[awdc_pkg::EV_WAKE]    = stop_mode && timeout && ctrl_reg.irq_en;
    ev_next[awdc_pkg::EV_HALL]    = hall_hit;
  end
  // sticky bits, write one to clear, set wins
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      status_reg <= awdc_pkg::STATUS_RESET;
      mask_reg   <= awdc_pkg::MASK_RESET;
    end else begin
      if (req.cyc && req.stb && req.we && !wb_ack_o && req.sel[0]
          && hit(req.adr, awdc_pkg::STATUS_INDEX)) begin
        status_reg <= (status_reg & ~req.dat[7:0]) | ev_next;
      end else begin
        status_reg <= status_reg | ev_next;
      end
      if (req.cyc && req.stb && req.we && !wb_ack_o && req.sel[0]
          && hit(req.adr, awdc_pkg::MASK_INDEX)) begin
        mask_reg <= req.dat[7:0] & awdc_pkg::EV_USED;
      end
    end
  end
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |((status_reg | ev_next) & mask_reg);
    end
  end
  // ****************************************************************
  // wishbone answer, one wait cycle
  // ****************************************************************
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req.cyc && req.stb && !wb_ack_o;
      wb_dat_o <= 32'h00000000;
      if (req.cyc && req.stb && !req.we && !wb_ack_o) begin
        if (hit(req.adr, awdc_pkg::CTRL_INDEX)) begin
          // restart and upper bits read zero
          wb_dat_o <= {27'h0000000, ctrl_reg};
        end else if (hit(req.adr, awdc_pkg::STATUS_INDEX)) begin
          wb_dat_o <= {24'h000000, status_reg};
        end else if (hit(req.adr, awdc_pkg::MASK_INDEX)) begin
          wb_dat_o <= {24'h000000, mask_reg};
        end
      end
    end
  end
  // ****************************************************************
  // checks
  // ****************************************************************
  a_flag_on_timeout: assert property (@(posedge sys_clk) disable iff (reset)
    timeout |=> ctrl_reg.flag) else $error("flag not set after timeout");
  a_flag_write_zero: assert property (@(posedge sys_clk) disable iff (reset)
    (ctrl_reg.flag && !flag_clear) |=> ctrl_reg.flag) else $error("flag lost");
  a_rst_en_sticky: assert property (@(posedge sys_clk) disable iff (reset)
    ctrl_reg.rst_en |=> ctrl_reg.rst_en) else $error("reset enable cleared");
  a_restart_clears_cnt: assert property (@(posedge sys_clk) disable iff (reset)
    restart |=> cnt_reg == '0) else $error("restart left counter");
  a_clear_restarts: assert property (@(posedge sys_clk) disable iff (reset)
    flag_clear |=> cnt_reg == '0) else $error("flag clear left counter");
  a_reset_run_only: assert property (@(posedge sys_clk) disable iff (reset)
    !sys_reset_n |-> $past(!stop_mode) && $past(ctrl_reg.rst_en))
    else $error("reset outside run mode");
  a_irq_stop_only: assert property (@(posedge sys_clk) disable iff (reset)
    !cpu_irq_n |-> $past(stop_mode) && $past(ctrl_reg.irq_en))
    else $error("interrupt outside stop mode");
  a_osc_gated: assert property (@(posedge sys_clk) disable iff (reset)
    !run_osc |=> cnt_reg == '0 && !tick) else $error("oscillator runs disabled");
  a_stop_pause: assert property (@(posedge sys_clk) disable iff (reset)
    (stop_mode && !ctrl_reg.irq_en && !ctrl_reg.cyclic) |=> $stable(cnt_reg)
      || cnt_reg == '0) else $error("counting in stop mode");
  a_ctrl_read_zero: assert property (@(posedge sys_clk) disable iff (reset)
    wb_ack_o |-> wb_dat_o[31:5] == '0) else $error("upper bits read nonzero");
  c_timeout_seen: cover property (@(posedge sys_clk) disable iff (reset) timeout);
  c_wd_reset: cover property (@(posedge sys_clk) disable iff (reset) !sys_reset_n);
  c_stop_irq: cover property (@(posedge sys_clk) disable iff (reset) !cpu_irq_n);
  c_hall_wake: cover property (@(posedge sys_clk) disable iff (reset) hall_hit);
endmodule // awdc_top
`default_nettype wire

// ==== testbench/awdc_cpu_model.sv ====
// cpu side classic wishbone master model for the watchdog control
`timescale 1ns/1ps
`default_nettype none
module awdc_cpu_model (
  input  wire logic                      sys_clk,
  input  wire logic                      wb_ack_o,
  input  wire logic [31:0]               wb_dat_o,
  output var  awdc_pkg::awdc_wb_req_type req
);
  // bus idle from time zero
  initial begin
    req = '0;
  end
  // one classic cycle: hold until ack, released lines show inverted values
  task automatic xfer(input logic w, input int unsigned idx, input logic [7:0] d,
                      output logic [31:0] q);
    @(posedge sys_clk);
    req <= '{cyc:1'b1, stb:1'b1, we:w, adr:8'(idx * 4), sel:4'hf, dat:{24'h0, d}};
    @(posedge sys_clk);
    // wait for ack as long as it takes, a hang is ended by the bench watchdog
    while (wb_ack_o !== 1'b1) begin
      @(posedge sys_clk);
    end
    q = wb_dat_o;
    req <= '{cyc:1'b0, stb:1'b0, we:~w, adr:~8'(idx * 4), sel:4'h0, dat:~{24'h0, d}};
  endtask
endmodule // awdc_cpu_model
`default_nettype wire

// ==== testbench/autonomous_watchdog_control_tb.sv ====
// self-checking bench of the watchdog control block
`timescale 1ns/1ps
`default_nettype none
module autonomous_watchdog_control_tb;
  localparam int unsigned CT = awdc_pkg::CTRL_INDEX;
  localparam int unsigned ST = awdc_pkg::STATUS_INDEX;
  localparam int unsigned MK = awdc_pkg::MASK_INDEX;
  logic                      sys_clk, reset, stop_mode, hall_irq_en, irq_a;
  logic [2:0]                hall_in;
  awdc_pkg::awdc_wb_req_type req;
  logic [31:0]               wb_dat_o, q;
  logic                      wb_ack_o, sys_reset_n, cpu_irq_n, wake_req;
  logic                      hall_power, analog_check, irq;
  int                        bad_count, n_checks, rst_cnt, wake_cnt, hall_cnt, n, m;
  awdc_top #(.TICK_DIV(4), .HALL_W(3)) i_dut (
    .sys_clk(sys_clk), .reset(reset), .wb_cyc_i(req.cyc), .wb_stb_i(req.stb),
    .wb_we_i(req.we), .wb_adr_i(req.adr), .wb_sel_i(req.sel), .wb_dat_i(req.dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .stop_mode(stop_mode),
    .hall_in(hall_in), .hall_irq_en(hall_irq_en), .sys_reset_n(sys_reset_n),
    .cpu_irq_n(cpu_irq_n), .wake_req(wake_req), .hall_power(hall_power),
    .analog_check(analog_check), .irq(irq));
  awdc_cpu_model i_cpu (.sys_clk(sys_clk), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
    .req(req));
  // ****************************************************************
  // clock, monitors and helpers
  // ****************************************************************
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // count the cycles in which system reset, wake request and hall power are active, seen at each edge
  always @(posedge sys_clk) begin
    if (sys_reset_n === 1'b0) rst_cnt++;
    if (wake_req === 1'b1) wake_cnt++;
    if (hall_power === 1'b1) hall_cnt++;
  end
  task automatic close_out();
    if (bad_count == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input int unsigned idx, input logic [7:0] d);
    i_cpu.xfer(1'b1, idx, d, q);
  endtask
  task automatic rd(input int unsigned idx);
    i_cpu.xfer(1'b0, idx, 8'h00, q);
  endtask
  // cycles until the system reset pulse shows
  task automatic time_reset(input int lo, input int hi);
    n = 0;
    while (sys_reset_n !== 1'b0 && n < 200) begin
      @(posedge sys_clk);
      n++;
    end
    chk(32'(n >= lo && n <= hi), 32'h1);
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset_values();
    rd(CT); chk(q, 32'h0);
    rd(ST); chk(q, 32'h0);
    rd(MK); chk(q, 32'h0);
    rd(8'h3f); chk(q, 32'h0);
  endtask
  task automatic t_reserved_bits();
    wr(CT, 8'he1);
    rd(CT); chk(q, 32'h01);
    m = rst_cnt;
    repeat (150) @(posedge sys_clk);
    rd(CT); chk(q, 32'h01);
    chk(32'(rst_cnt - m), 32'h0);
  endtask
  task automatic t_run_timeout();
    wr(CT, 8'h11);
    time_reset(32, 52);
    rd(CT); chk(q, 32'h13);
    wr(CT, 8'h01);
    rd(CT); chk(q, 32'h13);
    repeat (10) @(posedge sys_clk);
    wr(CT, 8'h13);
    time_reset(32, 52);
  endtask
  task automatic t_restart_hold();
    repeat (2) @(posedge sys_clk);
    m = rst_cnt;
    repeat (8) begin
      repeat (20) @(posedge sys_clk);
      wr(CT, 8'h31);
    end
    chk(32'(rst_cnt - m), 32'h0);
    wr(CT, 8'h30);
    time_reset(72, 92);
  endtask
  task automatic t_stop_wake();
    @(posedge sys_clk);
    stop_mode <= 1'b1;
    m = rst_cnt;
    n = wake_cnt;
    wr(CT, 8'h2b);
    repeat (100) @(posedge sys_clk);
    chk(32'(rst_cnt - m), 32'h0);
    chk(32'(wake_cnt - n), 32'h2);
    chk({31'h0, cpu_irq_n}, 32'h0);
    rd(ST); chk(q & 32'h3, 32'h3);
    wr(MK, 8'h00);
    repeat (3) @(posedge sys_clk);
    irq_a = irq;
    wr(MK, 8'h07);
    repeat (3) @(posedge sys_clk);
    chk({30'h0, irq_a, irq}, 32'h1);
    wr(CT, 8'h0a);
    repeat (3) @(posedge sys_clk);
    chk({31'h0, cpu_irq_n}, 32'h1);
  endtask
  task automatic t_cyclic();
    @(posedge sys_clk);
    hall_in <= 3'b001;
    hall_irq_en <= 1'b1;
    wr(ST, 8'h07);
    wr(CT, 8'h26);
    m = wake_cnt;
    n = 0;
    while (hall_power !== 1'b1 && n < 150) begin
      @(posedge sys_clk);
      n++;
    end
    chk(32'(n < 150), 32'h1);
    chk({31'h0, analog_check}, 32'h1);
    repeat (4) @(posedge sys_clk);
    chk(32'(wake_cnt - m), 32'h1);
    rd(ST); chk({31'h0, q[awdc_pkg::EV_HALL]}, 32'h1);
    wr(CT, 8'h02);
    wr(ST, 8'h07);
    m = hall_cnt;
    repeat (150) @(posedge sys_clk);
    chk(32'(hall_cnt - m), 32'h0);
  endtask
  task automatic t_second_reset();
    @(posedge sys_clk);
    reset <= 1'b1;
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    stop_mode <= 1'b0;
    rd(CT); chk(q, 32'h0);
    wr(CT, 8'h10);
    wr(CT, 8'h00);
    rd(CT); chk(q, 32'h10);
  endtask
  // main sequence
  initial begin
    reset = 1'b1;
    stop_mode = 1'b0;
    hall_in = 3'b000;
    hall_irq_en = 1'b0;
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    t_reset_values();
    t_reserved_bits();
    t_run_timeout();
    t_restart_hold();
    t_stop_wake();
    t_cyclic();
    t_second_reset();
    close_out();
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    close_out();
  end
endmodule // autonomous_watchdog_control_tb
`default_nettype wire
